// ### common/ccdp_pkg.sv
`default_nettype none
package ccdp_pkg;
  // register byte addresses on the bus
  localparam logic [11:0] ADDR_CLOCK_DIVIDER_CONTROL_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PLL_OUT_DIV = 12'h004;
  localparam logic [11:0] ADDR_FB_MULT = 12'h008;
  localparam logic [11:0] ADDR_OSC_CTRL = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  // clock_divider_control fields
  localparam int ROI_BIT = 15;
  localparam int DOZE_HI = 14;
  localparam int DOZE_LO = 12;
  localparam int RATIO_MODE_ENABLE_BIT = 11;
  localparam int FRCD_HI = 10;
  localparam int FRCD_LO = 8;
  localparam int PRE_HI = 3;
  localparam int PRE_LO = 0;
  // pll_output_divider fields
  localparam int VCO_HI = 9;
  localparam int VCO_LO = 8;
  localparam int P1_HI = 6;
  localparam int P1_LO = 4;
  localparam int P2_HI = 2;
  localparam int P2_LO = 0;
  // oscillator control fields
  localparam int NEW_OSCILLATOR_SELECT_HI = 10;
  localparam int NEW_OSCILLATOR_SELECT_LO = 8;
  localparam int COSC_HI = 14;
  localparam int COSC_LO = 12;
  localparam int SWREQ_BIT = 0;
  // reset values
  localparam logic [2:0] DOZE_RST = 3'h3;
  localparam logic [2:0] FRCD_RST = 3'h0;
  localparam logic [3:0] PRE_RST = 4'h1;
  localparam logic [1:0] VCO_RST = 2'h0;
  localparam logic [2:0] P1_RST = 3'h4;
  localparam logic [2:0] P2_RST = 3'h1;
  localparam logic [7:0] FB_RST = 8'h32;
  localparam logic [2:0] OSC_RST = 3'h0;
  localparam logic [2:0] OSC_FRC_PLL = 3'h1;
  localparam logic [2:0] DOZE_ZERO = 3'h0;
  localparam logic [2:0] POST_MIN = 3'h1;
  // clock switch settle time
  localparam int CLK_MHZ = 25;
  localparam int SWITCH_NS = 400;
  localparam int SWITCH_CYC = (SWITCH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SWITCH_CYC_W = 8'(SWITCH_CYC);
  localparam int CNT_W = 8;
  localparam int FREQ_W = 32;
  typedef enum logic [1:0] {CCDP_IDLE, CCDP_WAIT, CCDP_DONE} ccdp_sw_state_t;
endpackage
`default_nettype wire

// ### rtl/ccdp_core.sv
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - pll output frequency is input times multiplier over prescaler and both postscalers
// - new oscillator code 001 plus switch request starts switch to rc with pll
// - switch request bit reads one during switch, zero once done
// - doze ratio divides system clock into peripheral tick by two to the code, reset code 011
// - vco divider: 11 undivided, 10 by 2, 01 by 3, 00 by 4
// - input prescaler writable while pll runs
// - postscalers reset to four and one
module ccdp_core (
  input wire logic SYS_CLK, // system clock
  input wire logic NRST, // sync reset, active low
  input wire logic [11:0] PADDR, // apb address
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  input wire logic IRQ_EVENT, // interrupt occurrence pulse
  input wire logic PLL_RUNNING, // pll is operating
  input wire logic [15:0] FIN_KHZ, // pll input frequency
  output logic PERIPH_TICK, // peripheral clock enable tick
  output logic VCO_TICK, // vco divided output tick
  output logic [2:0] CUR_OSC, // active oscillator code
  output logic [2:0] FRC_POST, // rc postscaler code
  output logic [31:0] PLL_FOUT_KHZ // computed pll output frequency
);
  ////////////////////////////////////////////////////////////////////////
  logic roi_reg, roi_next;
  logic [2:0] doze_reg, doze_next;
  logic ratio_mode_enable_reg, ratio_mode_enable_next;
  logic [2:0] frcd_reg, frcd_next;
  logic [3:0] pre_reg, pre_next;
  logic [1:0] vco_reg, vco_next;
  logic [2:0] p1_reg, p1_next;
  logic [2:0] p2_reg, p2_next;
  logic [7:0] fb_reg, fb_next;
  logic [2:0] new_oscillator_select_reg, new_oscillator_select_next;
  logic [2:0] cosc_reg, cosc_next;
  logic swreq_reg, swreq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] cnt_reg, cnt_next;
  ccdp_pkg::ccdp_sw_state_t st_reg, st_next;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic [7:0] doze_ratio;
  logic [7:0] vco_ratio;
  logic periph_raw;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  // read data is loaded at the setup edge so it stands through the zero-wait access cycle
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign mapped = (PADDR == ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL) || (PADDR == ccdp_pkg::ADDR_PLL_OUT_DIV) ||
    (PADDR == ccdp_pkg::ADDR_FB_MULT) || (PADDR == ccdp_pkg::ADDR_OSC_CTRL) || (PADDR == ccdp_pkg::ADDR_STATUS);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    roi_next = roi_reg;
    doze_next = doze_reg;
    ratio_mode_enable_next = ratio_mode_enable_reg;
    frcd_next = frcd_reg;
    pre_next = pre_reg;
    vco_next = vco_reg;
    p1_next = p1_reg;
    p2_next = p2_reg;
    fb_next = fb_reg;
    new_oscillator_select_next = new_oscillator_select_reg;
    if (wr_acc && PADDR == ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL)
    begin
      roi_next = PWDATA[ccdp_pkg::ROI_BIT];
      frcd_next = PWDATA[ccdp_pkg::FRCD_HI:ccdp_pkg::FRCD_LO];
      pre_next = PWDATA[ccdp_pkg::PRE_HI:ccdp_pkg::PRE_LO];
      if (!ratio_mode_enable_reg)
        doze_next = PWDATA[ccdp_pkg::DOZE_HI:ccdp_pkg::DOZE_LO];
      if (!(PWDATA[ccdp_pkg::RATIO_MODE_ENABLE_BIT] && doze_next == ccdp_pkg::DOZE_ZERO))
        ratio_mode_enable_next = PWDATA[ccdp_pkg::RATIO_MODE_ENABLE_BIT];
    end
    if (wr_acc && PADDR == ccdp_pkg::ADDR_PLL_OUT_DIV)
    begin
      vco_next = PWDATA[ccdp_pkg::VCO_HI:ccdp_pkg::VCO_LO];
      // postscaler writes ignored while the pll runs; zero would stall the divider chain
      if (!PLL_RUNNING && PWDATA[ccdp_pkg::P1_HI:ccdp_pkg::P1_LO] >= ccdp_pkg::POST_MIN)
        p1_next = PWDATA[ccdp_pkg::P1_HI:ccdp_pkg::P1_LO];
      if (!PLL_RUNNING && PWDATA[ccdp_pkg::P2_HI:ccdp_pkg::P2_LO] >= ccdp_pkg::POST_MIN)
        p2_next = PWDATA[ccdp_pkg::P2_HI:ccdp_pkg::P2_LO];
    end
    if (wr_acc && PADDR == ccdp_pkg::ADDR_FB_MULT)
      fb_next = PWDATA[7:0];
    if (wr_acc && PADDR == ccdp_pkg::ADDR_OSC_CTRL && st_reg == ccdp_pkg::CCDP_IDLE)
      new_oscillator_select_next = PWDATA[ccdp_pkg::NEW_OSCILLATOR_SELECT_HI:ccdp_pkg::NEW_OSCILLATOR_SELECT_LO];
    // interrupt clears doze, wins over write
    if (roi_reg && IRQ_EVENT)
      ratio_mode_enable_next = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    swreq_next = swreq_reg;
    cosc_next = cosc_reg;
    case (st_reg)
      ccdp_pkg::CCDP_IDLE:
      begin
        if (wr_acc && PADDR == ccdp_pkg::ADDR_OSC_CTRL && PWDATA[ccdp_pkg::SWREQ_BIT])
        begin
          swreq_next = 1'b1;
          cnt_next = 8'h00;
          st_next = ccdp_pkg::CCDP_WAIT;
        end
      end
      ccdp_pkg::CCDP_WAIT:
      begin
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg + 8'h01 >= ccdp_pkg::SWITCH_CYC_W)
          st_next = ccdp_pkg::CCDP_DONE;
      end
      ccdp_pkg::CCDP_DONE:
      begin
        cosc_next = new_oscillator_select_reg;
        swreq_next = 1'b0;
        st_next = ccdp_pkg::CCDP_IDLE;
      end
      default:
        st_next = ccdp_pkg::CCDP_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    rdata_next = 32'h0;
    if (rd_setup)
    begin
      case (PADDR)
        ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL:
        begin
          rdata_next[ccdp_pkg::ROI_BIT] = roi_reg;
          rdata_next[ccdp_pkg::DOZE_HI:ccdp_pkg::DOZE_LO] = doze_reg;
          rdata_next[ccdp_pkg::RATIO_MODE_ENABLE_BIT] = ratio_mode_enable_reg;
          rdata_next[ccdp_pkg::FRCD_HI:ccdp_pkg::FRCD_LO] = frcd_reg;
          rdata_next[ccdp_pkg::PRE_HI:ccdp_pkg::PRE_LO] = pre_reg;
        end
        ccdp_pkg::ADDR_PLL_OUT_DIV:
        begin
          rdata_next[ccdp_pkg::VCO_HI:ccdp_pkg::VCO_LO] = vco_reg;
          rdata_next[ccdp_pkg::P1_HI:ccdp_pkg::P1_LO] = p1_reg;
          rdata_next[ccdp_pkg::P2_HI:ccdp_pkg::P2_LO] = p2_reg;
        end
        ccdp_pkg::ADDR_FB_MULT:
          rdata_next[7:0] = fb_reg;
        ccdp_pkg::ADDR_OSC_CTRL:
        begin
          rdata_next[ccdp_pkg::COSC_HI:ccdp_pkg::COSC_LO] = cosc_reg;
          rdata_next[ccdp_pkg::NEW_OSCILLATOR_SELECT_HI:ccdp_pkg::NEW_OSCILLATOR_SELECT_LO] = new_oscillator_select_reg;
          rdata_next[ccdp_pkg::SWREQ_BIT] = swreq_reg;
        end
        ccdp_pkg::ADDR_STATUS:
          rdata_next = PLL_FOUT_KHZ;
        default:
          rdata_next = 32'h0;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      roi_reg <= 1'b0;
      doze_reg <= ccdp_pkg::DOZE_RST;
      ratio_mode_enable_reg <= 1'b0;
      frcd_reg <= ccdp_pkg::FRCD_RST;
      pre_reg <= ccdp_pkg::PRE_RST;
      vco_reg <= ccdp_pkg::VCO_RST;
      p1_reg <= ccdp_pkg::P1_RST;
      p2_reg <= ccdp_pkg::P2_RST;
      fb_reg <= ccdp_pkg::FB_RST;
      new_oscillator_select_reg <= ccdp_pkg::OSC_RST;
      cosc_reg <= ccdp_pkg::OSC_RST;
      swreq_reg <= 1'b0;
      rdata_reg <= 32'h0;
      cnt_reg <= 8'h00;
      st_reg <= ccdp_pkg::CCDP_IDLE;
    end
    else
    begin
      roi_reg <= roi_next;
      doze_reg <= doze_next;
      ratio_mode_enable_reg <= ratio_mode_enable_next;
      frcd_reg <= frcd_next;
      pre_reg <= pre_next;
      vco_reg <= vco_next;
      p1_reg <= p1_next;
      p2_reg <= p2_next;
      fb_reg <= fb_next;
      new_oscillator_select_reg <= new_oscillator_select_next;
      cosc_reg <= cosc_next;
      swreq_reg <= swreq_next;
      rdata_reg <= rdata_next;
      cnt_reg <= cnt_next;
      st_reg <= st_next;
    end
  end
  assign PRDATA = rdata_reg;
  ////////////////////////////////////////////////////////////////////////
  // doze ratio decode
  assign doze_ratio = ratio_mode_enable_reg ? (8'h01 << doze_reg) : 8'h01;
  assign vco_ratio = 8'h04 - 8'(vco_reg);
  ccdp_ratio_div u_doze (
    .clk(SYS_CLK),
    .nrst(NRST),
    .ratio(doze_ratio),
    .tick(periph_raw)
  );
  ccdp_ratio_div u_vco (
    .clk(SYS_CLK),
    .nrst(NRST),
    .ratio(vco_ratio),
    .tick(VCO_TICK)
  );
  assign PERIPH_TICK = periph_raw;
  ccdp_freq_calc u_freq (
    .clk(SYS_CLK),
    .nrst(NRST),
    .fin_khz(FIN_KHZ),
    .mult(fb_reg),
    .pre(pre_reg),
    .post1(p1_reg),
    .post2(p2_reg),
    .fout_khz(PLL_FOUT_KHZ)
  );
  assign CUR_OSC = cosc_reg;
  assign FRC_POST = frcd_reg;
  ////////////////////////////////////////////////////////////////////////
  property p_post_default;
    @(posedge SYS_CLK) $rose(NRST) |-> (p1_reg == ccdp_pkg::P1_RST && p2_reg == ccdp_pkg::P2_RST);
  endproperty
  a_post_default: assert property (p_post_default) else $error("postscaler defaults wrong");
  property p_sw_start;
    @(posedge SYS_CLK) disable iff (!NRST)
      (st_reg == ccdp_pkg::CCDP_IDLE && wr_acc && PADDR == ccdp_pkg::ADDR_OSC_CTRL && PWDATA[0]) |=> swreq_reg;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("switch did not start");
  property p_sw_end;
    @(posedge SYS_CLK) disable iff (!NRST) $rose(swreq_reg) |-> ##[1:20] !swreq_reg;
  endproperty
  a_sw_end: assert property (p_sw_end) else $error("switch never finished");
  property p_cosc_done;
    @(posedge SYS_CLK) disable iff (!NRST) $fell(swreq_reg) |-> cosc_reg == new_oscillator_select_reg;
  endproperty
  a_cosc_done: assert property (p_cosc_done) else $error("oscillator not switched");
  property p_roi;
    @(posedge SYS_CLK) disable iff (!NRST) (roi_reg && IRQ_EVENT) |=> !ratio_mode_enable_reg;
  endproperty
  a_roi: assert property (p_roi) else $error("doze not cleared on interrupt");
  property p_doze_lock;
    @(posedge SYS_CLK) disable iff (!NRST) ratio_mode_enable_reg |=> $stable(doze_reg);
  endproperty
  a_doze_lock: assert property (p_doze_lock) else $error("doze ratio changed while enabled");
  property p_doze_nz;
    @(posedge SYS_CLK) disable iff (!NRST) ratio_mode_enable_reg |-> doze_reg != ccdp_pkg::DOZE_ZERO;
  endproperty
  a_doze_nz: assert property (p_doze_nz) else $error("doze enabled with zero ratio");
  property p_vco;
    @(posedge SYS_CLK) disable iff (!NRST)
      vco_ratio == ((vco_reg == 2'h3) ? 8'h01 : (vco_reg == 2'h2) ? 8'h02 : (vco_reg == 2'h1) ? 8'h03 : 8'h04);
  endproperty
  a_vco: assert property (p_vco) else $error("vco ratio decode wrong");
  property p_pre_run;
    @(posedge SYS_CLK) disable iff (!NRST)
      (wr_acc && PADDR == ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL) |=> pre_reg == $past(PWDATA[3:0]);
  endproperty
  a_pre_run: assert property (p_pre_run) else $error("prescaler write lost");
  property p_doze_rate;
    @(posedge SYS_CLK) disable iff (!NRST) (NRST && !ratio_mode_enable_reg) ##1 !ratio_mode_enable_reg |-> PERIPH_TICK;
  endproperty
  a_doze_rate: assert property (p_doze_rate) else $error("ratio one not every cycle");
  property p_doze_top;
    @(posedge SYS_CLK) disable iff (!NRST) (ratio_mode_enable_reg && doze_reg == 3'h6) |-> doze_ratio == 8'h40;
  endproperty
  a_doze_top: assert property (p_doze_top) else $error("doze code 110 not divide by 64");
  c_switch: cover property (@(posedge SYS_CLK) $fell(swreq_reg));
  c_roi: cover property (@(posedge SYS_CLK) roi_reg && IRQ_EVENT && ratio_mode_enable_reg);
  c_doze64: cover property (@(posedge SYS_CLK) ratio_mode_enable_reg && doze_reg == 3'h6);
  c_doze128: cover property (@(posedge SYS_CLK) ratio_mode_enable_reg && doze_reg == 3'h7);
endmodule
`default_nettype wire

// ### rtl/ccdp_freq_calc.sv
`timescale 1ns/1ps
`default_nettype none
// computes the pll output frequency in kHz from input frequency and divider settings
module ccdp_freq_calc (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic [15:0] fin_khz, // pll input frequency, kHz
  input wire logic [7:0] mult, // feedback multiplier
  input wire logic [3:0] pre, // input prescaler ratio
  input wire logic [2:0] post1, // first postscaler ratio
  input wire logic [2:0] post2, // second postscaler ratio
  output logic [31:0] fout_khz // pll output frequency, kHz
);
  logic [31:0] num;
  logic [31:0] den;
  logic [31:0] fout_reg;
  logic [31:0] fout_next;
  always_comb
  begin
    num = 32'(fin_khz) * 32'(mult);
    den = 32'(pre) * 32'(post1) * 32'(post2);
    // zero ratios are illegal; hold output at zero rather than divide by zero
    fout_next = (den == 32'h0) ? 32'h0 : num / den;
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      fout_reg <= 32'h0;
    else
      fout_reg <= fout_next;
  end
  assign fout_khz = fout_reg;
endmodule
`default_nettype wire

// ### rtl/ccdp_ratio_div.sv
`timescale 1ns/1ps
`default_nettype none
// divides the system clock by a programmable ratio, emitting a one-cycle tick
module ccdp_ratio_div (
  input wire logic clk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic [7:0] ratio, // divide ratio, 0 treated as 1
  output logic tick // one-cycle tick per ratio cycles
);
  // eight bits so the largest doze ratio of 128 does not wrap to zero
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  always_comb
  begin
    cnt_next = cnt_reg + 8'h01;
    tick_next = 1'b0;
    if (cnt_reg + 8'h01 >= ratio)
    begin
      cnt_next = 8'h00;
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign tick = tick_reg;
endmodule
`default_nettype wire

// ### testbench/ccdp_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ccdp_core_tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq_event = 1'b0;
  logic pll_running = 1'b0;
  logic [15:0] fin_khz = 16'h1f40;
  logic periph_tick;
  logic vco_tick;
  logic [2:0] cur_osc;
  logic [2:0] frc_post;
  logic [31:0] pll_fout_khz;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  integer seed = 32'hf3531a8e;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] rd_val;

  always #20 sys_clk = ~sys_clk;

  ccdp_core dut (
    .SYS_CLK(sys_clk),
    .NRST(nrst),
    .PADDR(paddr),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .IRQ_EVENT(irq_event),
    .PLL_RUNNING(pll_running),
    .FIN_KHZ(fin_khz),
    .PERIPH_TICK(periph_tick),
    .VCO_TICK(vco_tick),
    .CUR_OSC(cur_osc),
    .FRC_POST(frc_post),
    .PLL_FOUT_KHZ(pll_fout_khz)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int rnd(input int n);
    rnd = 1 + int'($unsigned($random(seed)) % n);
  endfunction

  // holds the whole request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    // read data stands in the access cycle and is taken at the ready edge
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic ticks(input int skip, input int n, input int exp_n, input logic vco);
    int c;
    c = 0;
    repeat (skip) @(posedge sys_clk);
    repeat (n)
    begin
      @(posedge sys_clk);
      if ((vco ? vco_tick : periph_tick) === 1'b1)
        c++;
    end
    check(32'(c), 32'(exp_n));
  endtask

  task automatic irq_pulse();
    @(posedge sys_clk);
    irq_event <= 1'b1;
    @(posedge sys_clk);
    irq_event <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // monitor: oldest read note against the data, error flag on every access
  always @(posedge sys_clk)
  begin
    cyc++;
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      check(prdata & msk_q.pop_front(), exp_q.pop_front());
    if (psel && penable && pready)
      check({31'h0, pslverr}, {31'h0, !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010})});
    if (cyc > 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  initial
  begin
    int p1, p2, pre, fin, i;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'h3001, 32'hffff);
    rd(ccdp_pkg::ADDR_PLL_OUT_DIV, 32'h0041, 32'hffff);
    ticks(10, 256, 256, 1'b0);
    apb(1'b1, ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'h0801);
    rd(ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'h0001, 32'hffff);
    for (int c = 1; c < 8; c++)
    begin
      apb(1'b1, ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'(c * 4096 + 32'h0801));
      apb(1'b1, ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'h2801);
      rd(ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'(c * 4096 + 32'h0801), 32'hffff);
      ticks(130, 256, 256 >> c, 1'b0);
      apb(1'b1, ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'h0001);
    end
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'(32'h6801 + k * 32'h8000));
      irq_pulse();
      rd(ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, k ? 32'he001 : 32'h6801, 32'hffff);
    end
    ticks(10, 256, 256, 1'b0);
    for (int v = 0; v < 4; v++)
    begin
      apb(1'b1, ccdp_pkg::ADDR_PLL_OUT_DIV, 32'(v * 256 + 32'h41));
      ticks(20, 120, 120 / (4 - v), 1'b1);
    end
    // postscalers must hold while the pll runs and refuse a zero ratio
    pll_running <= 1'b1;
    apb(1'b1, ccdp_pkg::ADDR_PLL_OUT_DIV, 32'h0077);
    rd(ccdp_pkg::ADDR_PLL_OUT_DIV, 32'h0041, 32'h0077);
    pll_running <= 1'b0;
    apb(1'b1, ccdp_pkg::ADDR_PLL_OUT_DIV, 32'h0003);
    rd(ccdp_pkg::ADDR_PLL_OUT_DIV, 32'h0040, 32'h0070);
    apb(1'b1, ccdp_pkg::ADDR_FB_MULT, 32'h96);
    for (i = 0; i < 6; i++)
    begin
      p1 = rnd(7);
      p2 = rnd(p1);
      pre = rnd(15);
      // input chosen as a multiple of all divisors so the quotient is exact
      fin = rnd(89) * p1 * p2 * pre;
      pll_running <= 1'b0;
      apb(1'b1, ccdp_pkg::ADDR_PLL_OUT_DIV, 32'(p1 * 16 + p2));
      pll_running <= 1'b1;
      fin_khz <= 16'(fin);
      apb(1'b1, ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'(i * 256 + pre));
      rd(ccdp_pkg::ADDR_CLOCK_DIVIDER_CONTROL_CTRL, 32'(i * 256 + pre), 32'h070f);
      check(32'(frc_post), 32'(i));
      check(pll_fout_khz, 32'(fin * 150 / (pre * p1 * p2)));
      rd(ccdp_pkg::ADDR_STATUS, 32'(fin * 150 / (pre * p1 * p2)), 32'hffffffff);
    end
    apb(1'b1, ccdp_pkg::ADDR_OSC_CTRL, 32'h0101);
    rd(ccdp_pkg::ADDR_OSC_CTRL, 32'h0001, 32'h7001);
    check(32'(cur_osc), 32'(ccdp_pkg::OSC_RST));
    i = 0;
    do
    begin
      rd(ccdp_pkg::ADDR_OSC_CTRL, 32'h0, 32'h0);
      i++;
    end
    while (rd_val[0] !== 1'b0 && i < 40);
    check(32'(cur_osc), 32'(ccdp_pkg::OSC_FRC_PLL));
    rd(ccdp_pkg::ADDR_OSC_CTRL, 32'h1000, 32'h7001);
    rd(12'h014, 32'h0, 32'h0);
    apb(1'b1, 12'h020, 32'hffffffff);
    rd(ccdp_pkg::ADDR_FB_MULT, 32'h96, 32'hff);
    // let the monitor take the last note, then make sure none was left unanswered
    @(posedge sys_clk);
    check(32'(exp_q.size()), 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
